/* rtl/acc_register_transfer_ops.v */
// execution of the accumulator register transfer instructions inside the cpu datapath
// Overview of operation
// - accumulator-to-auxiliary op copies all four accumulator bits to aux, one word, one cycle.
// - accumulator-to-pointer op copies accumulator bits 2..0 to pointer; bit 3 ignored.
// - combined op loads staging bits 7..4 from the auxiliary register.
// - combined op loads staging bits 3..0 from accumulator, same single cycle.
`timescale 1ns/1ps
`include "xfer_map.vh"

module acc_register_transfer_ops (
  clk_sys,
  srst,
  instr_valid,
  instr_word,
  acc_value,
  aux_load,
  aux_load_value,
  pointer_load,
  pointer_load_value,
  staging_load,
  staging_load_value,
  carry_load,
  carry_load_value,
  skip_request,
  aux_reg,
  pointer_reg,
  staging_reg,
  carry_flag,
  skip_next,
  xfer_done,
  xfer_claimed
);
  input  wire                 clk_sys;
  input  wire                 srst;
  input  wire                 instr_valid;
  input  wire [`INSTR_W-1:0]  instr_word;
  input  wire [`ACC_W-1:0]    acc_value;
  input  wire                 aux_load;
  input  wire [`AUX_W-1:0]    aux_load_value;
  input  wire                 pointer_load;
  input  wire [`PTR_W-1:0]    pointer_load_value;
  input  wire                 staging_load;
  input  wire [`STG_W-1:0]    staging_load_value;
  input  wire                 carry_load;
  input  wire                 carry_load_value;
  input  wire                 skip_request;
  output reg  [`AUX_W-1:0]    aux_reg;
  output reg  [`PTR_W-1:0]    pointer_reg;
  output reg  [`STG_W-1:0]    staging_reg;
  output reg                  carry_flag;
  output reg                  skip_next;
  output reg                  xfer_done;
  output wire                 xfer_claimed;

  wire                 hit_aux;
  wire                 hit_ptr;
  wire                 hit_stg;
  wire                 hit_any;

  reg  [`AUX_W-1:0]    next_aux_reg;
  reg  [`PTR_W-1:0]    next_pointer_reg;
  reg  [`STG_W-1:0]    next_staging_reg;
  reg                  next_carry_flag;
  reg                  next_skip_next;
  reg  [1:0]           aux_sel;
  reg  [1:0]           pointer_sel;
  reg  [1:0]           staging_sel;
  reg                  done_state;
  reg                  next_done_state;
  wire [`STG_W-1:0]    staging_xfer_value;

  genvar               gi;

  // source of each destination register in one cycle
  localparam [1:0]     SEL_HOLD   = 2'h0;
  localparam [1:0]     SEL_XFER   = 2'h1;
  localparam [1:0]     SEL_SIDE   = 2'h2;

  // completion tracker: idle, or showing the pulse for the cycle just executed
  localparam           DONE_IDLE  = 1'h0;
  localparam           DONE_PULSE = 1'h1;

  transfer_opcode_match u_match (
    .instr_valid                     (instr_valid),
    .instr_word                      (instr_word),
    .hit_acc_to_aux                  (hit_aux),
    .hit_acc_to_pointer_transfer     (hit_ptr),
    .hit_aux_acc_to_staging_transfer (hit_stg),
    .hit_any                         (hit_any)
  );

  // tells the rest of the decoder this word is handled here in its single cycle
  assign xfer_claimed = hit_any;

  // combined word for staging, one bit at a time; the high nibble reads the aux
  // value held before this edge, so a same-cycle aux side load cannot leak in
  generate
    for (gi = 0; gi < `STG_W; gi = gi + 1) begin : g_stg_bit
      if (gi >= `STG_HI_LSB) begin : g_hi
        assign staging_xfer_value[gi] = aux_reg[gi-`STG_HI_LSB];
      end else begin : g_lo
        assign staging_xfer_value[gi] = acc_value[gi-`STG_LO_LSB];
      end
    end
  endgenerate

  // the transfer wins over a side load of the same register: only one
  // instruction executes per cycle, so a side load alongside it is a decoder fault
  always @* begin
    aux_sel = SEL_HOLD;
    if (hit_aux) begin
      aux_sel = SEL_XFER;
    end else if (aux_load) begin
      aux_sel = SEL_SIDE;
    end
  end

  always @* begin
    pointer_sel = SEL_HOLD;
    if (hit_ptr) begin
      pointer_sel = SEL_XFER;
    end else if (pointer_load) begin
      pointer_sel = SEL_SIDE;
    end
  end

  always @* begin
    staging_sel = SEL_HOLD;
    if (hit_stg) begin
      staging_sel = SEL_XFER;
    end else if (staging_load) begin
      staging_sel = SEL_SIDE;
    end
  end

  always @* begin
    case (aux_sel)
      SEL_XFER: begin
        next_aux_reg = acc_value;
      end
      SEL_SIDE: begin
        next_aux_reg = aux_load_value;
      end
      default: begin
        next_aux_reg = aux_reg;
      end
    endcase
  end

  // pointer register takes only the low three accumulator bits
  always @* begin
    case (pointer_sel)
      SEL_XFER: begin
        next_pointer_reg = acc_value[`PTR_SRC_MSB:0];
      end
      SEL_SIDE: begin
        next_pointer_reg = pointer_load_value;
      end
      default: begin
        next_pointer_reg = pointer_reg;
      end
    endcase
  end

  always @* begin
    case (staging_sel)
      SEL_XFER: begin
        next_staging_reg = staging_xfer_value;
      end
      SEL_SIDE: begin
        next_staging_reg = staging_load_value;
      end
      default: begin
        next_staging_reg = staging_reg;
      end
    endcase
  end

  // carry and skip are only touched by other instructions; a transfer masks
  // any stray request issued in the same cycle
  always @* begin
    next_carry_flag = carry_flag;
    next_skip_next  = 1'b0;
    if (!hit_any) begin
      if (carry_load) begin
        next_carry_flag = carry_load_value;
      end
      next_skip_next = skip_request;
    end else begin
      next_carry_flag = carry_flag;
      next_skip_next  = 1'b0;
    end
  end

  // back-to-back transfers keep the pulse high for as long as they last
  always @* begin
    case (done_state)
      DONE_IDLE: begin
        next_done_state = hit_any ? DONE_PULSE : DONE_IDLE;
      end
      DONE_PULSE: begin
        next_done_state = hit_any ? DONE_PULSE : DONE_IDLE;
      end
      default: begin
        next_done_state = DONE_IDLE;
      end
    endcase
  end

  // pulse read straight from the state flop, so it carries no decode glitch
  always @* begin
    xfer_done = (done_state == DONE_PULSE);
  end

  always @(posedge clk_sys) begin
    if (srst) begin
      aux_reg     <= `AUX_RESET;
      pointer_reg <= `PTR_RESET;
      staging_reg <= `STG_RESET;
      carry_flag  <= `CARRY_RESET;
      skip_next   <= 1'b0;
      done_state  <= DONE_IDLE;
    end else begin
      aux_reg     <= next_aux_reg;
      pointer_reg <= next_pointer_reg;
      staging_reg <= next_staging_reg;
      carry_flag  <= next_carry_flag;
      skip_next   <= next_skip_next;
      // completion pulse one edge after the single execute cycle
      done_state  <= next_done_state;
    end
  end
endmodule

/* rtl/xfer_map.vh */
// opcode encodings, register widths, field positions and reset values for the transfer block
`ifndef XFER_MAP_VH
`define XFER_MAP_VH

`define INSTR_W            10
`define ACC_W              4
`define AUX_W              4
`define PTR_W              3
`define STG_W              8

`define OP_ACC_TO_AUX      10'h00e
`define OP_ACC_TO_PTR      10'h029
`define OP_AUX_ACC_TO_STG  10'h01a

`define STG_HI_MSB         7
`define STG_HI_LSB         4
`define STG_LO_MSB         3
`define STG_LO_LSB         0
`define PTR_SRC_MSB        2

`define AUX_RESET          4'h0
`define PTR_RESET          3'h0
`define STG_RESET          8'h00
`define CARRY_RESET        1'b0

`define XFER_CYCLES        1
`define XFER_WORDS         1

`endif

/* rtl/transfer_opcode_match.v */
// opcode match for the three register transfer instructions
`timescale 1ns/1ps
`include "xfer_map.vh"

module transfer_opcode_match (
  instr_valid,
  instr_word,
  hit_acc_to_aux,
  hit_acc_to_pointer_transfer,
  hit_aux_acc_to_staging_transfer,
  hit_any
);
  input  wire                 instr_valid;
  input  wire [`INSTR_W-1:0]  instr_word;
  output wire                 hit_acc_to_aux;
  output wire                 hit_acc_to_pointer_transfer;
  output wire                 hit_aux_acc_to_staging_transfer;
  output wire                 hit_any;

  // full ten-bit compare: each op is one word, no operand field to mask
  assign hit_acc_to_aux                  = instr_valid && (instr_word == `OP_ACC_TO_AUX);
  assign hit_acc_to_pointer_transfer     = instr_valid && (instr_word == `OP_ACC_TO_PTR);
  assign hit_aux_acc_to_staging_transfer = instr_valid && (instr_word == `OP_AUX_ACC_TO_STG);
  assign hit_any = hit_acc_to_aux | hit_acc_to_pointer_transfer | hit_aux_acc_to_staging_transfer;
endmodule

/* test/xfer_properties.sv */
// assertions on the transfer block ports
`timescale 1ns/1ps
`include "xfer_map.vh"
module xfer_properties (
  input wire                 clk_sys,
  input wire                 srst,
  input wire                 instr_valid,
  input wire                 xfer_claimed,
  input wire                 xfer_done,
  input wire                 carry_flag,
  input wire                 skip_next,
  input wire [`INSTR_W-1:0]  instr_word,
  input wire [`ACC_W-1:0]    acc_value,
  input wire [`AUX_W-1:0]    aux_reg,
  input wire [`PTR_W-1:0]    pointer_reg,
  input wire [`STG_W-1:0]    staging_reg
);
  wire ta = instr_valid && instr_word == `OP_ACC_TO_AUX;
  wire tp = instr_valid && instr_word == `OP_ACC_TO_PTR;
  wire ts = instr_valid && instr_word == `OP_AUX_ACC_TO_STG;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  a_aux_copy: assert property (ta |=> aux_reg == $past(acc_value)) else $error("aux");
  a_ptr_low: assert property (tp |=> pointer_reg == $past(acc_value[2:0])) else $error("ptr");
  a_stg_high: assert property (ts |=> staging_reg[7:4] == $past(aux_reg)) else $error("hi");
  a_stg_low: assert property (ts |=> staging_reg[3:0] == $past(acc_value)) else $error("lo");
  a_carry_kept: assert property (xfer_claimed |=> $stable(carry_flag) && !skip_next) else $error("cy");
  a_done_pulse: assert property (xfer_claimed |=> xfer_done) else $error("done");
  a_done_quiet: assert property (!xfer_claimed |=> !xfer_done) else $error("quiet");
endmodule
bind acc_register_transfer_ops xfer_properties i_props (.clk_sys(clk_sys), .srst(srst), .instr_valid(instr_valid),
  .xfer_claimed(xfer_claimed), .xfer_done(xfer_done), .carry_flag(carry_flag), .skip_next(skip_next),
  .instr_word(instr_word),
  .acc_value(acc_value), .aux_reg(aux_reg), .pointer_reg(pointer_reg), .staging_reg(staging_reg));

/* test/acc_register_transfer_ops_tb_top.sv */
// random bench with a reference model for the transfer block
`timescale 1ns/1ps
`include "xfer_map.vh"
module acc_register_transfer_ops_tb_top;
  reg          clk_sys = 1'b0;
  reg          srst = 1'b1;
  reg          iv = 1'b0;
  reg [9:0]    w = 10'h000;
  reg [24:0]   v = 25'h0;
  reg [31:0]   rnd = 32'h0;
  wire [3:0]   aux;
  wire [2:0]   ptr;
  wire [7:0]   stg;
  wire         cy, sk, dn, cl;
  integer      seed = 32'h8b18, fails = 0, compares = 0, n, h, a = 0, p = 0, s = 0, c = 0, k = 0, d = 0;
  always #20 clk_sys = ~clk_sys;
  // one random word feeds every side input so that no input is tied off
  acc_register_transfer_ops i_dut (.clk_sys(clk_sys), .srst(srst), .instr_valid(iv), .instr_word(w),
    .acc_value(v[3:0]), .aux_load(v[4]), .aux_load_value(v[8:5]), .pointer_load(v[9]),
    .pointer_load_value(v[12:10]), .staging_load(v[13]), .staging_load_value(v[21:14]),
    .carry_load(v[22]), .carry_load_value(v[23]), .skip_request(v[24]), .aux_reg(aux), .pointer_reg(ptr),
    .staging_reg(stg), .carry_flag(cy), .skip_next(sk), .xfer_done(dn), .xfer_claimed(cl));
  task check(input [7:0] seen, input [7:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    for (n = 0; n < 400; n = n + 1) begin
      @(posedge clk_sys);
      // rare mid-run resets check that reset overrides transfers
      srst <= n < 4 || $random(seed) % 97 == 0;
      rnd = $random(seed);
      iv <= rnd[0];
      h = $random(seed) & 3;
      rnd = $random(seed);
      w <= h == 0 ? `OP_ACC_TO_AUX : h == 1 ? `OP_ACC_TO_PTR : h == 2 ? `OP_AUX_ACC_TO_STG : rnd[9:0];
      rnd = $random(seed);
      v <= rnd[24:0];
      @(negedge clk_sys);
      h = iv && (w == `OP_ACC_TO_AUX || w == `OP_ACC_TO_PTR || w == `OP_AUX_ACC_TO_STG);
      check(cl, h);
      check(aux, a);
      check(dn, d);
      check(ptr, p);
      check(stg[7:4], s / 16);
      check(stg[3:0], s % 16);
      check({cy, sk}, c * 2 + k);
      // staging first: it takes the aux value from before this edge
      s = srst ? 0 : iv && w == `OP_AUX_ACC_TO_STG ? a * 16 + v[3:0] : v[13] ? v[21:14] : s;
      a = srst ? 0 : iv && w == `OP_ACC_TO_AUX ? v[3:0] : v[4] ? v[8:5] : a;
      p = srst ? 0 : iv && w == `OP_ACC_TO_PTR ? v[2:0] : v[9] ? v[12:10] : p;
      c = srst ? 0 : !h && v[22] ? v[23] : c;
      k = !srst && !h && v[24];
      d = !srst && h;
    end
    $display("random transfer test done");
    final_report;
  end
  initial begin
    #40000;
    fails = fails + 1;
    final_report;
  end
endmodule
